// *** hdl/or_and_move_instruction_exec.sv ***
`timescale 1ns/1ps

module or_and_move_instruction_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rd_data_i,
  output logic [6:0] file_rd_addr_o,
  output or_move_pkg::file_wr_s file_wr_o,
  output logic [7:0] acc_o,
  output logic zero_o,
  output or_move_pkg::phase_e phase_o
);

  or_move_pkg::phase_e phase_r;
  or_move_pkg::op_e op_r;
  logic [13:0] ir_r;
  logic [7:0] operand_r;
  logic [7:0] result_r;
  logic [7:0] acc_r;
  logic zero_r;
  logic [6:0] rd_addr_r;
  or_move_pkg::file_wr_s wr_r;
  logic [7:0] alu_result;
  or_move_pkg::effect_s effect;
  logic [7:0] lit_w;
  logic dest_w;

  assign lit_w = ir_r[or_move_pkg::LIT_MSB:0];
  assign dest_w = ir_r[or_move_pkg::DEST_BIT];

  // sort a word into one of the four handled operations
  function automatic or_move_pkg::op_e decode(input logic [13:0] w);
    logic [1:0] cls;
    logic [3:0] sub;
    cls = w[or_move_pkg::CLASS_MSB:or_move_pkg::CLASS_LSB];
    sub = w[or_move_pkg::SUB_MSB:or_move_pkg::SUB_LSB];
    if (cls == or_move_pkg::CLASS_LITERAL && sub == or_move_pkg::SUB_OR_LIT) begin
      decode = or_move_pkg::OP_OR_LIT;
    end else if (cls == or_move_pkg::CLASS_LITERAL && sub[3:2] == or_move_pkg::SUB_LOAD_LIT_HI) begin
      decode = or_move_pkg::OP_LOAD_LIT;
    end else if (cls == or_move_pkg::CLASS_BYTE && sub == or_move_pkg::SUB_OR_FILE) begin
      decode = or_move_pkg::OP_OR_FILE;
    end else if (cls == or_move_pkg::CLASS_BYTE && sub == or_move_pkg::SUB_MOVE_FILE) begin
      decode = or_move_pkg::OP_MOVE_FILE;
    end else begin
      decode = or_move_pkg::OP_NONE;
    end
  endfunction

  // four phases per instruction cycle, free running while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= or_move_pkg::PH_Q1;
    end else if (ce_i) begin
      case (phase_r)
        or_move_pkg::PH_Q1: phase_r <= or_move_pkg::PH_Q2;
        or_move_pkg::PH_Q2: phase_r <= or_move_pkg::PH_Q3;
        or_move_pkg::PH_Q3: phase_r <= or_move_pkg::PH_Q4;
        or_move_pkg::PH_Q4: phase_r <= or_move_pkg::PH_Q1;
        default: phase_r <= or_move_pkg::PH_Q1;
      endcase
    end
  end

  // Q1: latch and decode; the read address goes out for the whole of Q2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_r <= or_move_pkg::WORD_RESET;
      op_r <= or_move_pkg::OP_NONE;
      rd_addr_r <= or_move_pkg::ADDR_RESET;
    end else if (ce_i && phase_r == or_move_pkg::PH_Q1) begin
      ir_r <= instr_i;
      op_r <= decode(instr_i);
      rd_addr_r <= instr_i[or_move_pkg::ADDR_MSB:0];
    end
  end

  // Q2: fetch the operand, literal from the word or data from the file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_r <= or_move_pkg::BYTE_RESET;
    end else if (ce_i && phase_r == or_move_pkg::PH_Q2) begin
      if (op_r == or_move_pkg::OP_OR_LIT || op_r == or_move_pkg::OP_LOAD_LIT) begin
        operand_r <= lit_w;
      end else begin
        operand_r <= file_rd_data_i;  // same clock domain, no synchroniser
      end
    end
  end

  or_move_alu u_alu (
    .op_i(op_r),
    .dest_i(dest_w),
    .acc_i(acc_r),
    .operand_i(operand_r),
    .result_o(alu_result),
    .effect_o(effect)
  );

  // Q3: process; the file write strobe is raised for exactly the Q4 phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= or_move_pkg::BYTE_RESET;
      wr_r <= '0;
    end else if (ce_i) begin
      if (phase_r == or_move_pkg::PH_Q3) begin
        result_r <= alu_result;
        wr_r.en <= effect.to_file;
        wr_r.addr <= ir_r[or_move_pkg::ADDR_MSB:0];
        wr_r.data <= alu_result;
      end else begin
        wr_r.en <= 1'b0;
      end
    end
  end

  // Q4: write the accumulator and the zero flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= or_move_pkg::ACC_RESET;
      zero_r <= or_move_pkg::ZERO_RESET;
    end else if (ce_i && phase_r == or_move_pkg::PH_Q4) begin
      if (effect.to_acc) begin
        acc_r <= result_r;
      end
      if (effect.sets_zero) begin
        zero_r <= (result_r == or_move_pkg::BYTE_RESET);
      end
    end
  end

  // all outputs come straight from flip-flops
  assign file_rd_addr_o = rd_addr_r;
  assign file_wr_o = wr_r;
  assign acc_o = acc_r;
  assign zero_o = zero_r;
  assign phase_o = phase_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_q4_of(or_move_pkg::op_e op);
    ce_i && phase_r == or_move_pkg::PH_Q4 && op_r == op;
  endsequence

  sequence s_full_cycle;
    (ce_i && phase_r == or_move_pkg::PH_Q1) ##1 ce_i [*3];
  endsequence

  a_or_lit_acc: assert property (
    s_q4_of(or_move_pkg::OP_OR_LIT) |=> acc_r == ($past(acc_r) | $past(lit_w)))
    else $error("literal OR left a wrong accumulator");

  a_or_lit_zero: assert property (
    s_q4_of(or_move_pkg::OP_OR_LIT) |-> !wr_r.en ##1 (zero_r == (acc_r == 8'h00)))
    else $error("literal OR zero flag or file write wrong");

  a_phase_walk: assert property (
    s_full_cycle |=> phase_r == or_move_pkg::PH_Q1)
    else $error("instruction cycle is not four phases");

  a_move_to_acc: assert property (
    s_q4_of(or_move_pkg::OP_MOVE_FILE) ##0 !dest_w |=> acc_r == $past(operand_r))
    else $error("register move to accumulator failed");

  a_move_to_file: assert property (
    s_q4_of(or_move_pkg::OP_MOVE_FILE) ##0 dest_w
      |-> wr_r.en && wr_r.data == operand_r && wr_r.addr == ir_r[6:0])
    else $error("register move back to file failed");

  a_load_lit: assert property (
    s_q4_of(or_move_pkg::OP_LOAD_LIT) |=> acc_r == $past(lit_w) && $stable(zero_r))
    else $error("literal load wrong or touched zero flag");

  a_or_file_dest: assert property (
    s_q4_of(or_move_pkg::OP_OR_FILE) ##0 dest_w
      |-> wr_r.en && wr_r.data == (acc_r | operand_r) ##1 $stable(acc_r))
    else $error("register OR to file wrong");

  a_write_in_q4: assert property (
    wr_r.en |-> phase_r == or_move_pkg::PH_Q4)
    else $error("file write outside the fourth phase");

  // a stalled core must not drift, or a slow enable would corrupt a half-done instruction
  a_stall_freeze: assert property (
    !ce_i |=> $stable(phase_r) && $stable(acc_r) && $stable(zero_r) && $stable(wr_r))
    else $error("state moved while the clock enable was low");

  // the word is taken only at the end of the first phase; the read address follows it
  a_word_latch: assert property (
    ce_i && phase_r == or_move_pkg::PH_Q1
      |=> ir_r == $past(instr_i) && rd_addr_r == ir_r[or_move_pkg::ADDR_MSB:0])
    else $error("instruction word not latched at the end of the first phase");

  // register OR back into the accumulator also refreshes the zero flag
  a_or_file_acc: assert property (
    s_q4_of(or_move_pkg::OP_OR_FILE) ##0 !dest_w
      |=> acc_r == ($past(acc_r) | $past(operand_r)) && zero_r == (acc_r == 8'h00))
    else $error("register OR into the accumulator wrong");

  // the zero flag follows the moved value whichever way the move goes
  a_move_zero: assert property (
    s_q4_of(or_move_pkg::OP_MOVE_FILE) |=> zero_r == ($past(operand_r) == 8'h00))
    else $error("register move left a wrong zero flag");

  // literal load writes the accumulator only, never the file
  a_load_no_write: assert property (
    s_q4_of(or_move_pkg::OP_LOAD_LIT) |-> !wr_r.en)
    else $error("literal load raised a file write");

  // unknown words act as a no-op so that foreign opcodes do no damage
  a_none_quiet: assert property (
    s_q4_of(or_move_pkg::OP_NONE) |-> !wr_r.en ##1 ($stable(acc_r) && $stable(zero_r)))
    else $error("unknown word changed state");

endmodule // or_and_move_instruction_exec

// *** hdl/or_move_alu.sv ***
`timescale 1ns/1ps

// combinational data path for the third phase
module or_move_alu (
  input wire or_move_pkg::op_e op_i,
  input wire logic dest_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] operand_i,
  output logic [7:0] result_o,
  output or_move_pkg::effect_s effect_o
);

  // result and where it goes; unknown words do nothing at all
  always_comb begin
    result_o = operand_i;
    effect_o = '0;
    case (op_i)
      or_move_pkg::OP_OR_LIT: begin
        result_o = acc_i | operand_i;
        effect_o.to_acc = 1'b1;
        effect_o.sets_zero = 1'b1;
      end
      or_move_pkg::OP_OR_FILE: begin
        result_o = acc_i | operand_i;
        effect_o.to_acc = (dest_i == or_move_pkg::DEST_ACC);
        effect_o.to_file = (dest_i != or_move_pkg::DEST_ACC);
        effect_o.sets_zero = 1'b1;
      end
      or_move_pkg::OP_MOVE_FILE: begin
        result_o = operand_i;
        effect_o.to_acc = (dest_i == or_move_pkg::DEST_ACC);
        effect_o.to_file = (dest_i != or_move_pkg::DEST_ACC);
        effect_o.sets_zero = 1'b1;
      end
      or_move_pkg::OP_LOAD_LIT: begin
        result_o = operand_i;
        effect_o.to_acc = 1'b1;  // flags stay untouched
      end
      default: begin
        result_o = operand_i;
        effect_o = '0;
      end
    endcase
  end

endmodule // or_move_alu

// *** hdl/or_move_pkg.sv ***
package or_move_pkg;

  // word and operand widths
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  // field positions inside the instruction word
  localparam int CLASS_MSB = 13;
  localparam int CLASS_LSB = 12;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam int LIT_MSB = 7;
  localparam int ADDR_MSB = 6;

  // encodings of the top two bits, the next nibble and the destination bit
  localparam logic [1:0] CLASS_LITERAL = 2'h3;
  localparam logic [1:0] CLASS_BYTE = 2'h0;
  localparam logic [3:0] SUB_OR_LIT = 4'h8;
  localparam logic [3:0] SUB_OR_FILE = 4'h4;
  localparam logic [3:0] SUB_MOVE_FILE = 4'h8;
  localparam logic [1:0] SUB_LOAD_LIT_HI = 2'h0;  // low two bits of the nibble are don't-care
  localparam logic DEST_ACC = 1'b0;

  // values after reset
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [13:0] WORD_RESET = 14'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_OR_LIT,
    OP_OR_FILE,
    OP_MOVE_FILE,
    OP_LOAD_LIT
  } op_e;

  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } phase_e;

  // write port toward the file registers
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_s;

  // what the execute stage does with its result
  typedef struct packed {
    logic to_acc;
    logic to_file;
    logic sets_zero;
  } effect_s;

endpackage

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0] file_rd_data_i = 8'h00;
  logic [6:0] file_rd_addr_o;
  or_move_pkg::file_wr_s file_wr_o;
  logic [7:0] acc_o;
  logic zero_o;
  or_move_pkg::phase_e phase_o;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  // 200 MHz
  always #2.5 clk_i = ~clk_i;

  or_and_move_instruction_exec or_and_move_instruction_exec_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .instr_i(instr_i),
    .file_rd_data_i(file_rd_data_i),
    .file_rd_addr_o(file_rd_addr_o),
    .file_wr_o(file_wr_o),
    .acc_o(acc_o),
    .zero_o(zero_o),
    .phase_o(phase_o)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one instruction, entered at the falling edge inside the first phase
  task automatic run(input logic [13:0] w, input logic [7:0] fd, input logic wr,
                     input logic [7:0] wd, input logic [7:0] acc, input logic z);
    instr_i = w;
    @(negedge clk_i);
    chk(16'(phase_o), 16'(or_move_pkg::PH_Q2));
    chk(16'(file_rd_addr_o), 16'(w[6:0]));
    instr_i = ~w; // must be ignored outside the first phase
    file_rd_data_i = fd;
    @(negedge clk_i);
    file_rd_data_i = ~fd; // stale data after the read phase, to catch a late sample
    @(negedge clk_i);
    chk(16'(file_wr_o.en), 16'(wr));
    if (wr) begin
      chk({1'b0, file_wr_o.addr, file_wr_o.data}, {1'b0, w[6:0], wd});
    end
    @(negedge clk_i);
    chk(16'(file_wr_o.en), 16'h0000);
    chk({7'h00, zero_o, acc_o}, {7'h00, z, acc});
  endtask

  task automatic t_literal;
    run(14'h3800, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      run(14'h305A | 14'(i << 8), 8'hA5, 1'b0, 8'h00, 8'h5A, 1'b1);
    end
    run(14'h309A, 8'h00, 1'b0, 8'h00, 8'h9A, 1'b1);
    run(14'h3835, 8'hFF, 1'b0, 8'h00, 8'hBF, 1'b0);
    run(14'h38FF, 8'h00, 1'b0, 8'h00, 8'hFF, 1'b0);
  endtask

  task automatic t_or_file;
    run(14'h3091, 8'h00, 1'b0, 8'h00, 8'h91, 1'b0);
    run(14'h0415, 8'h13, 1'b0, 8'h00, 8'h93, 1'b0);
    run(14'h04FF, 8'h13, 1'b1, 8'h93, 8'h93, 1'b0);
    run(14'h3000, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    run(14'h0480, 8'h00, 1'b1, 8'h00, 8'h00, 1'b1);
  endtask

  task automatic t_move;
    run(14'h0822, 8'hC3, 1'b0, 8'h00, 8'hC3, 1'b0);
    run(14'h087F, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    run(14'h08FF, 8'h7E, 1'b1, 8'h7E, 8'h00, 1'b0);
  endtask

  // unknown word, clock-enable stall, then reset in mid-instruction
  task automatic t_misc;
    run(14'h0AFF, 8'h55, 1'b0, 8'h00, 8'h00, 1'b0);
    instr_i = 14'h38F0;
    ce_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(16'(phase_o), 16'(or_move_pkg::PH_Q1));
    ce_i = 1'b1;
    run(14'h38F0, 8'h00, 1'b0, 8'h00, 8'hF0, 1'b0);
    instr_i = 14'h3833;
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    chk({5'h00, file_wr_o.en, phase_o, acc_o}, 16'h0000);
    rst_i = 1'b0;
    run(14'h3811, 8'h00, 1'b0, 8'h00, 8'h11, 1'b0);
  endtask

  // a hang is cut short well past the expected run of about 80 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    t_literal();
    t_or_file();
    t_move();
    t_misc();
    wrap_up();
  end
endmodule // tb_top
